/* core/decimal_format_regs.svh */
// field positions, character codes and reset values of the decimal format decoder
`ifndef DECIMAL_FORMAT_REGS_SVH
`define DECIMAL_FORMAT_REGS_SVH

// indicator word layout
`define IND_SCALE_MSB      31
`define IND_SCALE_LSB      24
`define IND_TYPE_MSB       7
`define IND_TYPE_LSB       5
`define IND_SIZE_MSB       4
`define IND_SIZE_LSB       0

// data type codes
`define TYPE_OVER_LAST     3'h0
`define TYPE_OVER_FIRST    3'h1
`define TYPE_SIGN_LAST     3'h2
`define TYPE_SIGN_FIRST    3'h3
`define TYPE_UNSIGNED      3'h4
`define TYPE_PACKED        3'h5
`define TYPE_BINARY        3'h6

// character codes
`define CHR_SPACE          8'h20
`define CHR_PLUS           8'h2B
`define CHR_MINUS          8'h2D
`define CHR_ZERO           8'h30
`define CHR_NINE           8'h39
`define CHR_POS_ONE        8'h41
`define CHR_POS_NINE       8'h49
`define CHR_NEG_ONE        8'h4A
`define CHR_NEG_NINE       8'h52
`define CHR_OPEN_BRACE     8'h7B
`define CHR_CLOSE_BRACE    8'h7D

// packed sign nibbles and largest digit nibble
`define NIB_POS_A          4'hC
`define NIB_POS_B          4'hF
`define NIB_NEG            4'hD
`define NIB_MAX_DIGIT      4'h9

// reset values
`define RST_COUNT          6'h00
`define RST_EXPONENT       9'h000

`endif

/* core/decimal_format_pkg.sv */
// types shared by the decimal format decoder
package decimal_format_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01
   } dec_state_t;

   typedef enum logic [2:0] {
      ROLE_PLAIN       = 3'b000,
      ROLE_OVERPUNCH   = 3'b001,
      ROLE_SIGN        = 3'b010,
      ROLE_PACKED      = 3'b011,
      ROLE_PACKED_SIGN = 3'b100,
      ROLE_BINARY      = 3'b101
   } byte_role_t;

   typedef struct packed {
      logic       hi_valid;
      logic       lo_valid;
      logic [3:0] hi;
      logic [3:0] lo;
      logic [7:0] raw;
   } digit_lane_t;

   typedef struct packed {
      logic       neg;
      logic       sets_sign;
      logic       bad;
   } byte_flags_t;

endpackage : decimal_format_pkg

/* core/decimal_byte_decoder.sv */
// decodes one memory byte according to its role in the operand
`timescale 1ns/1ns
`include "decimal_format_regs.svh"
module decimal_byte_decoder
   import decimal_format_pkg::*;
(
   // byte and role
   input  wire logic [7:0]  byte_i,
   input  wire byte_role_t  role_i,
   input  wire logic        force_hi_zero_i,
   // decoded
   output digit_lane_t      lane_o,
   output byte_flags_t      flags_o
);

   always_comb begin
      lane_o           = '0;
      flags_o          = '0;
      lane_o.raw       = byte_i;
      unique case (role_i)
         ROLE_PLAIN: begin
            lane_o.lo_valid = 1'b1;
            if (byte_i == `CHR_SPACE) begin
               lane_o.lo = 4'h0;
            end else if (byte_i >= `CHR_ZERO && byte_i <= `CHR_NINE) begin
               lane_o.lo = byte_i[3:0];
            end else begin
               flags_o.bad = 1'b1;
            end
         end
         ROLE_OVERPUNCH: begin
            lane_o.lo_valid   = 1'b1;
            flags_o.sets_sign = 1'b1;
            if (byte_i == `CHR_SPACE || byte_i == `CHR_PLUS
                || byte_i == `CHR_OPEN_BRACE) begin
               lane_o.lo = 4'h0;
            end else if (byte_i >= `CHR_ZERO && byte_i <= `CHR_NINE) begin
               lane_o.lo = byte_i[3:0];
            end else if (byte_i >= `CHR_POS_ONE && byte_i <= `CHR_POS_NINE) begin
               lane_o.lo = 4'(byte_i - `CHR_POS_ONE + 8'h01);
            end else if (byte_i == `CHR_MINUS || byte_i == `CHR_CLOSE_BRACE) begin
               lane_o.lo   = 4'h0;
               flags_o.neg = 1'b1;
            end else if (byte_i >= `CHR_NEG_ONE && byte_i <= `CHR_NEG_NINE) begin
               lane_o.lo   = 4'(byte_i - `CHR_NEG_ONE + 8'h01);
               flags_o.neg = 1'b1;
            end else begin
               flags_o.bad = 1'b1;
            end
         end
         ROLE_SIGN: begin
            flags_o.sets_sign = 1'b1;
            if (byte_i == `CHR_MINUS) begin
               flags_o.neg = 1'b1;
            end else if (byte_i != `CHR_PLUS) begin
               flags_o.bad = 1'b1;
            end
         end
         ROLE_PACKED: begin
            lane_o.hi_valid = 1'b1;
            lane_o.lo_valid = 1'b1;
            lane_o.hi       = force_hi_zero_i ? 4'h0 : byte_i[7:4];
            lane_o.lo       = byte_i[3:0];
            flags_o.bad     = (!force_hi_zero_i && byte_i[7:4] > `NIB_MAX_DIGIT)
                              || byte_i[3:0] > `NIB_MAX_DIGIT;
         end
         ROLE_PACKED_SIGN: begin
            lane_o.hi_valid   = 1'b1;
            lane_o.hi         = force_hi_zero_i ? 4'h0 : byte_i[7:4];
            flags_o.sets_sign = 1'b1;
            flags_o.neg       = byte_i[3:0] == `NIB_NEG;
            flags_o.bad       = (!force_hi_zero_i && byte_i[7:4] > `NIB_MAX_DIGIT)
                                || !(byte_i[3:0] == `NIB_POS_A || byte_i[3:0] == `NIB_POS_B
                                     || byte_i[3:0] == `NIB_NEG);
         end
         ROLE_BINARY: begin
            lane_o.lo_valid = 1'b0;
         end
         default: begin
            flags_o.bad = 1'b1;
         end
      endcase
   end

endmodule : decimal_byte_decoder

/* core/decimal_operand_format_decoder.sv */
// decimal operand format decoder: indicator decode and byte string walk
// How it works
// - The scale field is read as a signed byte from -128 to 127.
// - With scaling on, the operand is the integer times ten to the negated scale.
// - Operations that do not use scaling see an exponent of zero whatever the field holds.
// - The size field is an unsigned five-bit length from 0 to 31.
// - All types but packed take size plus one bytes.
// - For packed, size counts digits, not bytes.
// - An even packed size is raised to the next odd one with a zero leading digit.
// - Types 0 and 1 carry sign and digit in the last or first byte.
// - Types 2 and 3 carry a separate plus or minus byte, trailing or leading.
// - Each unpacked digit byte is the character code of its digit, or a space for zero.
// - Packed bytes hold two digits, the last byte holding the lowest digit and the sign.
// - Packed signs C or F are positive and D negative.
// - A bad type or bad operand byte abandons the operation with a fault.
`timescale 1ns/1ns
`include "decimal_format_regs.svh"
module decimal_operand_format_decoder
   import decimal_format_pkg::*;
#(
   parameter int ACC_WIDTH = 32
)
(
   // clock and reset
   input  wire logic                 CLOCK_I,
   input  wire logic                 RST_B_I,
   // indicator source
   input  wire logic [ACC_WIDTH-1:0] FIRST_ACCUMULATOR_I,
   input  wire logic [ACC_WIDTH-1:0] SECOND_ACCUMULATOR_I,
   input  wire logic                 USE_SECOND_I,
   input  wire logic                 USE_SCALE_I,
   input  wire logic                 START_I,
   // memory byte stream
   input  wire logic                 BYTE_VALID_I,
   input  wire logic [7:0]           BYTE_I,
   output logic                      BYTE_READY_O,
   // operand description
   output logic                      BUSY_O,
   output logic [5:0]                BYTE_COUNT_O,
   output logic [5:0]                DIGIT_COUNT_O,
   output logic signed [8:0]         EXPONENT_O,
   output logic [2:0]                DATA_TYPE_O,
   // decoded stream
   output logic                      LANE_VALID_O,
   output digit_lane_t               LANE_O,
   output logic                      DONE_O,
   output logic                      NEGATIVE_O,
   output logic                      FAULT_O
);

   dec_state_t     state;
   logic [2:0]     dtype;
   logic           size_even;
   logic [5:0]     remaining;
   logic           first_byte;
   logic           neg;
   byte_role_t     role;
   logic           force_hi_zero;
   digit_lane_t    lane;
   byte_flags_t    flags;
   logic           take;
   logic           last_byte;

   // indicator fields of the selected accumulator
   logic [ACC_WIDTH-1:0] ind;
   logic signed [7:0]    scale;
   logic [2:0]           ind_type;
   logic [4:0]           ind_size;
   logic [4:0]           packed_digits;
   logic [5:0]           next_bytes;
   logic [5:0]           next_digits;
   logic signed [8:0]    next_exponent;
   logic                 type_bad;

   assign ind           = USE_SECOND_I ? SECOND_ACCUMULATOR_I : FIRST_ACCUMULATOR_I;
   assign scale         = signed'(ind[`IND_SCALE_MSB:`IND_SCALE_LSB]);
   assign ind_type      = ind[`IND_TYPE_MSB:`IND_TYPE_LSB];
   assign ind_size      = ind[`IND_SIZE_MSB:`IND_SIZE_LSB];
   assign packed_digits = ind_size | 5'h01;
   assign type_bad      = ind_type > `TYPE_BINARY;

   always_comb begin
      next_bytes  = 6'({1'b0, ind_size} + 6'h01);
      next_digits = next_bytes;
      unique case (ind_type)
         `TYPE_PACKED: begin
            next_bytes  = 6'(({1'b0, packed_digits} + 6'h01) >> 1);
            next_digits = {1'b0, packed_digits};
         end
         `TYPE_SIGN_LAST, `TYPE_SIGN_FIRST: begin
            next_digits = {1'b0, ind_size};
         end
         `TYPE_BINARY: begin
            next_digits = 6'h00;
         end
         default: begin
            next_digits = next_bytes;
         end
      endcase
   end

   // scaled operand value = integer * 10 ** exponent
   assign next_exponent = USE_SCALE_I ? -9'(scale) : `RST_EXPONENT;

   assign last_byte  = remaining == 6'h01;
   assign BYTE_READY_O = state == ST_RUN;
   assign take       = BYTE_READY_O && BYTE_VALID_I;

   // role of the byte now offered
   always_comb begin
      role          = ROLE_PLAIN;
      force_hi_zero = 1'b0;
      unique case (dtype)
         `TYPE_OVER_LAST: begin
            role = last_byte ? ROLE_OVERPUNCH : ROLE_PLAIN;
         end
         `TYPE_OVER_FIRST: begin
            role = first_byte ? ROLE_OVERPUNCH : ROLE_PLAIN;
         end
         `TYPE_SIGN_LAST: begin
            role = last_byte ? ROLE_SIGN : ROLE_PLAIN;
         end
         `TYPE_SIGN_FIRST: begin
            role = first_byte ? ROLE_SIGN : ROLE_PLAIN;
         end
         `TYPE_UNSIGNED: begin
            role = ROLE_PLAIN;
         end
         `TYPE_PACKED: begin
            role          = last_byte ? ROLE_PACKED_SIGN : ROLE_PACKED;
            force_hi_zero = first_byte && size_even;
         end
         `TYPE_BINARY: begin
            role = ROLE_BINARY;
         end
         default: begin
            role = ROLE_PLAIN;
         end
      endcase
   end

   decimal_byte_decoder u_byte_decoder (
      .byte_i          (BYTE_I),
      .role_i          (role),
      .force_hi_zero_i (force_hi_zero),
      .lane_o          (lane),
      .flags_o         (flags)
   );

   // sequencing
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (START_I && !type_bad) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (take && (flags.bad || last_byte)) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // operand description latched at start
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         dtype         <= 3'h0;
         size_even     <= 1'b0;
         BYTE_COUNT_O  <= `RST_COUNT;
         DIGIT_COUNT_O <= `RST_COUNT;
         EXPONENT_O    <= `RST_EXPONENT;
      end else if (state == ST_IDLE && START_I && !type_bad) begin
         dtype         <= ind_type;
         size_even     <= !ind_size[0];
         BYTE_COUNT_O  <= next_bytes;
         DIGIT_COUNT_O <= next_digits;
         EXPONENT_O    <= next_exponent;
      end
   end

   // byte position
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         remaining  <= `RST_COUNT;
         first_byte <= 1'b0;
      end else if (state == ST_IDLE && START_I && !type_bad) begin
         remaining  <= next_bytes;
         first_byte <= 1'b1;
      end else if (take) begin
         remaining  <= 6'(remaining - 6'h01);
         first_byte <= 1'b0;
      end
   end

   // sign of the operand
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         neg <= 1'b0;
      end else if (state == ST_IDLE && START_I) begin
         neg <= 1'b0;
      end else if (take && dtype == `TYPE_BINARY && first_byte) begin
         neg <= BYTE_I[7];
      end else if (take && flags.sets_sign) begin
         neg <= flags.neg;
      end
   end

   // decoded lane output
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         LANE_VALID_O <= 1'b0;
         LANE_O       <= '0;
      end else begin
         LANE_VALID_O <= take && !flags.bad;
         if (take) begin
            LANE_O <= lane;
         end
      end
   end

   // completion and fault pulses
   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         DONE_O     <= 1'b0;
         NEGATIVE_O <= 1'b0;
         FAULT_O    <= 1'b0;
      end else begin
         DONE_O  <= take && last_byte && !flags.bad;
         FAULT_O <= (state == ST_IDLE && START_I && type_bad)
                    || (take && flags.bad);
         if (take && last_byte && !flags.bad) begin
            if (dtype == `TYPE_BINARY && first_byte) begin
               NEGATIVE_O <= BYTE_I[7];
            end else if (flags.sets_sign) begin
               NEGATIVE_O <= flags.neg;
            end else begin
               NEGATIVE_O <= neg;
            end
         end
      end
   end

   assign BUSY_O      = state == ST_RUN;
   assign DATA_TYPE_O = dtype;

endmodule : decimal_operand_format_decoder

/* tb/decimal_operand_format_decoder_checker.sv */
// assertions on the ports of the decimal operand format decoder
`timescale 1ns/1ns
module decimal_operand_format_decoder_checker #(
   parameter int ACC_WIDTH = 32
)
(
   // clock and reset
   input wire logic                 CLOCK_I,
   input wire logic                 RST_B_I,
   // indicator side
   input wire logic [ACC_WIDTH-1:0] FIRST_ACCUMULATOR_I,
   input wire logic [ACC_WIDTH-1:0] SECOND_ACCUMULATOR_I,
   input wire logic                 USE_SECOND_I,
   input wire logic                 USE_SCALE_I,
   input wire logic                 START_I,
   input wire logic                 BYTE_VALID_I,
   // design outputs
   input wire logic                 BYTE_READY_O,
   input wire logic                 BUSY_O,
   input wire logic [5:0]           BYTE_COUNT_O,
   input wire logic [5:0]           DIGIT_COUNT_O,
   input wire logic signed [8:0]    EXPONENT_O,
   input wire logic [2:0]           DATA_TYPE_O,
   input wire logic                 LANE_VALID_O,
   input wire logic                 DONE_O,
   input wire logic                 NEGATIVE_O,
   input wire logic                 FAULT_O
);
   logic [ACC_WIDTH-1:0] ind;
   logic [2:0]           ty;
   logic [4:0]           sz;
   logic [5:0]           pk_dig;
   logic signed [8:0]    neg_sc;
   logic                 take;
   logic                 take_ok;

   assign ind     = USE_SECOND_I ? SECOND_ACCUMULATOR_I : FIRST_ACCUMULATOR_I;
   assign ty      = ind[7:5];
   assign sz      = ind[4:0];
   assign pk_dig  = {1'b0, sz | 5'h01};
   assign neg_sc  = 9'sh000 - $signed({ind[31], ind[31:24]});
   assign take    = START_I && !BUSY_O;
   assign take_ok = take && ty != 3'h7;

   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);

   property p_take_busy;
      take_ok |=> BUSY_O && !FAULT_O && DATA_TYPE_O == $past(ty);
   endproperty
   a_take_busy: assert property (p_take_busy) else $error("start not taken");
   property p_unpacked_count;
      take_ok && ty != 3'h5 |=> BYTE_COUNT_O == {1'b0, $past(sz)} + 6'h01;
   endproperty
   a_unpacked_count: assert property (p_unpacked_count) else $error("byte count");
   property p_packed_count;
      take_ok && ty == 3'h5 |=> DIGIT_COUNT_O == $past(pk_dig)
         && BYTE_COUNT_O == ($past(pk_dig) + 6'h01) >> 1;
   endproperty
   a_packed_count: assert property (p_packed_count) else $error("packed count");
   property p_scaled;
      take_ok && USE_SCALE_I |=> EXPONENT_O == $past(neg_sc);
   endproperty
   a_scaled: assert property (p_scaled) else $error("scaled exponent");
   property p_unscaled;
      take_ok && !USE_SCALE_I |=> EXPONENT_O == 9'sh000;
   endproperty
   a_unscaled: assert property (p_unscaled) else $error("unscaled exponent");
   property p_bad_type;
      take && ty == 3'h7 |=> FAULT_O && !BUSY_O ##1 !FAULT_O;
   endproperty
   a_bad_type: assert property (p_bad_type) else $error("bad type not refused");
   property p_byte_answer;
      BYTE_VALID_I && BYTE_READY_O |=> LANE_VALID_O || FAULT_O;
   endproperty
   a_byte_answer: assert property (p_byte_answer) else $error("byte unanswered");
   property p_done;
      DONE_O |-> !BUSY_O ##1 !DONE_O;
   endproperty
   a_done: assert property (p_done) else $error("done pulse wrong");
   property p_hold;
      BUSY_O && $past(BUSY_O) |-> $stable(BYTE_COUNT_O) && $stable(EXPONENT_O);
   endproperty
   a_hold: assert property (p_hold) else $error("description moved");

   c_done_neg: cover property (DONE_O && NEGATIVE_O);
   c_fault: cover property (FAULT_O);
   c_scaled: cover property (take_ok && USE_SCALE_I);
endmodule : decimal_operand_format_decoder_checker

bind decimal_operand_format_decoder decimal_operand_format_decoder_checker #(
   .ACC_WIDTH(ACC_WIDTH)
) u_checker (
   .CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I),
   .FIRST_ACCUMULATOR_I(FIRST_ACCUMULATOR_I), .SECOND_ACCUMULATOR_I(SECOND_ACCUMULATOR_I),
   .USE_SECOND_I(USE_SECOND_I), .USE_SCALE_I(USE_SCALE_I), .START_I(START_I),
   .BYTE_VALID_I(BYTE_VALID_I), .BYTE_READY_O(BYTE_READY_O), .BUSY_O(BUSY_O),
   .BYTE_COUNT_O(BYTE_COUNT_O), .DIGIT_COUNT_O(DIGIT_COUNT_O), .EXPONENT_O(EXPONENT_O),
   .DATA_TYPE_O(DATA_TYPE_O), .LANE_VALID_O(LANE_VALID_O), .DONE_O(DONE_O),
   .NEGATIVE_O(NEGATIVE_O), .FAULT_O(FAULT_O)
);

/* tb/decimal_operand_format_decoder_tb_top.sv */
// self-checking bench for the decimal operand format decoder
`timescale 1ns/1ns
module decimal_operand_format_decoder_tb_top import decimal_format_pkg::*;;
   typedef struct {
      logic [31:0] ind;
      logic        sec;
      logic        scl;
      logic [31:0] bytes;
      logic [5:0]  bc;
      logic [5:0]  dc;
      logic [15:0] val;
      logic        neg;
   } row_t;

   logic               clk = 1'b0;
   logic               rst_b = 1'b0;
   logic [31:0]        first_acc = 32'h00000000;
   logic [31:0]        second_acc = 32'h00000000;
   logic               use_second = 1'b0;
   logic               use_scale = 1'b0;
   logic               start = 1'b0;
   logic               byte_valid = 1'b0;
   logic [7:0]         byte_data = 8'h00;
   logic               byte_ready, busy, lane_valid, done, negative, fault;
   logic [5:0]         byte_count, digit_count;
   logic signed [8:0]  exponent;
   logic [2:0]         data_type;
   digit_lane_t        lane;
   logic [15:0]        got_val;
   logic [8:0]         exp9;
   int                 num_checks = 0;
   int                 miscompares = 0;

   // indicator, select, scale, bytes, byte count, digits, value, sign
   row_t rows [15] = '{
      '{32'hFF000002, 1'b0, 1'b1, 32'h33395000, 6'h03, 6'h03, 16'h018D, 1'b1},
      '{32'h80000002, 1'b1, 1'b1, 32'h33394700, 6'h03, 6'h03, 16'h018D, 1'b0},
      '{32'h7F000022, 1'b0, 1'b1, 32'h4C393700, 6'h03, 6'h03, 16'h018D, 1'b1},
      '{32'h05000043, 1'b1, 1'b0, 32'h3339372D, 6'h04, 6'h03, 16'h018D, 1'b1},
      '{32'h00000063, 1'b0, 1'b0, 32'h2B333937, 6'h04, 6'h03, 16'h018D, 1'b0},
      '{32'h00000082, 1'b0, 1'b0, 32'h33393700, 6'h03, 6'h03, 16'h018D, 1'b0},
      '{32'h000000A3, 1'b1, 1'b0, 32'h397D0000, 6'h02, 6'h03, 16'h018D, 1'b1},
      '{32'h000000A3, 1'b0, 1'b1, 32'h397C0000, 6'h02, 6'h03, 16'h018D, 1'b0},
      '{32'h000000C1, 1'b0, 1'b0, 32'hFE730000, 6'h02, 6'h00, 16'h0000, 1'b1},
      '{32'h000000C1, 1'b1, 1'b0, 32'h018D0000, 6'h02, 6'h00, 16'h0000, 1'b0},
      '{32'h000000A2, 1'b0, 1'b0, 32'h057C0000, 6'h02, 6'h03, 16'h0039, 1'b0},
      '{32'h000000A0, 1'b0, 1'b0, 32'h3F000000, 6'h01, 6'h01, 16'h0000, 1'b0},
      '{32'h00000000, 1'b0, 1'b0, 32'h4A000000, 6'h01, 6'h01, 16'h0001, 1'b1},
      '{32'h00000021, 1'b0, 1'b0, 32'h7D350000, 6'h02, 6'h02, 16'h0005, 1'b1},
      '{32'h00000081, 1'b1, 1'b0, 32'h20340000, 6'h02, 6'h02, 16'h0004, 1'b0}
   };

   decimal_operand_format_decoder dut (
      .CLOCK_I(clk), .RST_B_I(rst_b), .FIRST_ACCUMULATOR_I(first_acc),
      .SECOND_ACCUMULATOR_I(second_acc), .USE_SECOND_I(use_second), .USE_SCALE_I(use_scale),
      .START_I(start), .BYTE_VALID_I(byte_valid), .BYTE_I(byte_data),
      .BYTE_READY_O(byte_ready), .BUSY_O(busy), .BYTE_COUNT_O(byte_count),
      .DIGIT_COUNT_O(digit_count), .EXPONENT_O(exponent), .DATA_TYPE_O(data_type),
      .LANE_VALID_O(lane_valid), .LANE_O(lane), .DONE_O(done), .NEGATIVE_O(negative),
      .FAULT_O(fault)
   );

   initial begin
      forever #25 clk = ~clk;
   end

   task automatic check_value(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : check_value

   task automatic check_flag(input logic got, input logic exp);
      check_value({31'h0, got}, {31'h0, exp});
   endtask : check_flag

   task automatic close_out();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   task automatic start_op(input logic [31:0] ind, input logic sec, input logic scl);
      @(posedge clk);
      first_acc  <= sec ? 32'hFFFFFFFF : ind;
      second_acc <= sec ? ind : 32'hFFFFFFFF;
      use_second <= sec;
      use_scale  <= scl;
      start      <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
   endtask : start_op

   // streams n bytes back to back, folding decoded digits into a value
   task automatic feed(input logic [31:0] b, input int n, output logic [15:0] val);
      val = 16'h0000;
      byte_valid <= 1'b1;
      byte_data  <= b[31:24];
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         if (i < n - 1) byte_data <= b[23 - 8 * i -: 8];
         else byte_valid <= 1'b0;
         #1;
         if (lane_valid === 1'b1) check_value(lane.raw, b[31 - 8 * i -: 8]);
         if (lane_valid === 1'b1 && lane.hi_valid === 1'b1) val = val * 16'h000A + lane.hi;
         if (lane_valid === 1'b1 && lane.lo_valid === 1'b1) val = val * 16'h000A + lane.lo;
      end
   endtask : feed

   initial begin
      repeat (11) @(posedge clk);
      #1;
      check_flag(busy, 1'b0);
      check_flag(byte_ready, 1'b0);
      check_value(byte_count, 6'h00);
      @(posedge clk);
      rst_b <= 1'b1;
      foreach (rows[r]) begin
         start_op(rows[r].ind, rows[r].sec, rows[r].scl);
         feed(rows[r].bytes, rows[r].bc, got_val);
         exp9 = rows[r].scl ? 9'h000 - {rows[r].ind[31], rows[r].ind[31:24]} : 9'h000;
         check_flag(done, 1'b1);
         check_value(byte_count, rows[r].bc);
         check_value(digit_count, rows[r].dc);
         check_value(data_type, rows[r].ind[7:5]);
         check_value({23'h000000, exponent}, {23'h000000, exp9});
         check_value(got_val, rows[r].val);
         check_flag(negative, rows[r].neg);
         $display("row %0d finished", r);
      end
      start_op(32'h000000E0, 1'b0, 1'b0);
      #1;
      check_flag(fault, 1'b1);
      check_flag(busy, 1'b0);
      $display("bad type test finished");
      start_op(32'h00000082, 1'b0, 1'b0);
      feed(32'h335A3300, 2, got_val);
      check_flag(fault, 1'b1);
      check_flag(busy, 1'b0);
      check_flag(done, 1'b0);
      $display("bad byte test finished");
      start_op(32'h0000009F, 1'b0, 1'b0);
      @(posedge clk);
      start     <= 1'b1;
      first_acc <= 32'h000000A3;
      @(posedge clk);
      start <= 1'b0;
      #1;
      check_flag(busy, 1'b1);
      check_flag(byte_ready, 1'b1);
      check_value(byte_count, 6'h20);
      check_value(digit_count, 6'h20);
      check_value(data_type, 3'h4);
      @(posedge clk);
      rst_b <= 1'b0;
      @(posedge clk);
      #1;
      check_flag(busy, 1'b0);
      check_value(byte_count, 6'h00);
      @(posedge clk);
      rst_b <= 1'b1;
      $display("busy start and reset test finished");
      start_op(32'h00000082, 1'b0, 1'b0);
      feed(32'h33393700, 3, got_val);
      check_flag(done, 1'b1);
      check_value(got_val, 16'h018D);
      check_flag(negative, 1'b0);
      $display("restart after reset test finished");
      close_out();
   end

   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      $display("CHECK FAILED at %0t watchdog expired", $time);
      close_out();
   end
endmodule : decimal_operand_format_decoder_tb_top
